// ---- hw/epc_irq_unit.v ----
// Purpose: External pin and two-group pin-change interrupt unit with an
//          AXI4-Lite register slave and a vector request to the core.
// Assumes: Single 125 MHz clock, synchronous active-high reset; pins are
//          asynchronous and are synchronised before any logic reads them.
// Notes:   Pin activity is caught on the clock after a two-stage
//          synchroniser; in a real part this front end is clockless.
//
// Notes on behaviour
// - Every reset source restarts execution at vector address 0x0000.
// - External pin vector 0x0001, pin-change group 0 0x0002, group 1 0x0003.
// - Timer 1 sources at 0x0005..0x0007, timer 0 sources at 0x0008..0x000A.
// - Pins trigger requests even when driven as outputs by the part.
// - Any enabled toggle in 7:0 requests group 0; in 15:8 requests group 1.
// - Pin changes are detected without the I/O clock for wake from sleep.
// - Sense field: 00 low level, 01 any change, 10 falling, 11 rising.
// - Level sensing requests continuously while the pin stays low and enabled.
// - Low level and edges on the external pin are seen without the I/O clock.
// - A level gone before start-up ends still wakes, but takes no interrupt.
// - External interrupt fires only with global enable and its mask bit set.
// - Mask bit 6 enables the external pin interrupt, served at its vector.
// - Mask bit 5 enables group 1, bit 4 group 0, each with own vector.
// - Bits 7 and 3:0 of mask and flag registers read as zero.
// - Edge or change sets flag bit 6; vector when flag, mask, global set.
// - External flag clears on vector entry or when software writes one.
// - The external flag is held clear while low-level sensing is selected.
// - Group 1 flag bit 5 set on request; cleared by vector entry or write one.
// - Group 0 flag bit 4 set on request; cleared by vector entry or write one.
// - Pin-change masks at 0x20 (group 1) and 0x12 (group 0), reset to zero.
`timescale 1ns/1ps
`include "epc_defs.vh"

module epc_irq_unit #(
    parameter PC_PINS = 16
) (
    input  wire                clk,
    input  wire                rst,
    // AXI4-Lite slave
    input  wire [`EPC_ADDR_W-1:0] s_axi_awaddr,
    input  wire                s_axi_awvalid,
    output wire                s_axi_awready,
    input  wire [31:0]         s_axi_wdata,
    input  wire [3:0]          s_axi_wstrb,
    input  wire                s_axi_wvalid,
    output wire                s_axi_wready,
    output reg  [1:0]          s_axi_bresp,
    output reg                 s_axi_bvalid,
    input  wire                s_axi_bready,
    input  wire [`EPC_ADDR_W-1:0] s_axi_araddr,
    input  wire                s_axi_arvalid,
    output wire                s_axi_arready,
    output reg  [31:0]         s_axi_rdata,
    output reg  [1:0]          s_axi_rresp,
    output reg                 s_axi_rvalid,
    input  wire                s_axi_rready,
    // Pins (input side of the pad, so outputs driven by the part count)
    input  wire                ext_irq_pin,
    input  wire [PC_PINS-1:0]  pin_change_input,
    // Requests of other sources, active high levels
    input  wire [5:0]          tmr_irq_req,
    input  wire                wdt_irq_req,
    // Core side
    input  wire                start_up_done,
    input  wire                vec_ack,
    output wire                irq_req,
    output reg  [15:0]         irq_vector,
    output wire                wake_req,
    output reg  [15:0]         reset_vector
);

    // ------------------------------------------------------------------
    // Pin synchronisers and change detection
    // ------------------------------------------------------------------
    reg                 ext_meta_q;
    reg                 ext_sync_q;
    reg                 ext_prev_q;
    reg [PC_PINS-1:0]   pc_meta_q;
    reg [PC_PINS-1:0]   pc_sync_q;
    reg [PC_PINS-1:0]   pc_prev_q;

    // Two flops before use; only the second feeds edge logic
    always @(posedge clk)
    begin
        ext_meta_q <= ext_irq_pin;
        ext_sync_q <= ext_meta_q;
        pc_meta_q  <= pin_change_input;
        pc_sync_q  <= pc_meta_q;
        ext_prev_q <= ext_sync_q;
        pc_prev_q  <= pc_sync_q;
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    reg [7:0] mcu_control_q;
    reg [7:0] irq_mask_q;
    reg [7:0] irq_flags_q;
    reg [7:0] irq_flags_d;
    reg [7:0] pc_mask_hi_q;
    reg [7:0] pc_mask_lo_q;
    reg       gie_q;

    wire [1:0] ext_sense = mcu_control_q[1:0];
    wire       ext_level = (ext_sense == `EPC_SENSE_LOW);

    // Sense decode of the external pin
    reg ext_edge;
    always @*
    begin
        case (ext_sense)
            `EPC_SENSE_ANY:  ext_edge = ext_sync_q ^ ext_prev_q;
            `EPC_SENSE_FALL: ext_edge = ext_prev_q & ~ext_sync_q;
            `EPC_SENSE_RISE: ext_edge = ~ext_prev_q & ext_sync_q;
            default:         ext_edge = 1'b0;
        endcase
    end

    // Per-pin enabled toggles gathered per group
    wire [PC_PINS-1:0] pc_mask = {pc_mask_hi_q, pc_mask_lo_q};
    wire [PC_PINS-1:0] pc_hit;
    genvar gi;
    generate
        for (gi = 0; gi < PC_PINS; gi = gi + 1)
        begin : g_pc
            assign pc_hit[gi] = pc_mask[gi] & (pc_sync_q[gi] ^ pc_prev_q[gi]);
        end
    endgenerate
    wire pc_lo_evt = |pc_hit[7:0];
    wire pc_hi_evt = |pc_hit[PC_PINS-1:8];

    // Level request is live, not latched, while the pin is low
    wire ext_level_req = ext_level & ~ext_sync_q;

    // ------------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------------
    reg                   aw_have_q;
    reg                   w_have_q;
    reg [`EPC_ADDR_W-1:0] aw_addr_q;
    reg [7:0]             w_byte_q;
    reg                   w_strb_q;

    assign s_axi_awready = ~aw_have_q & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_have_q & ~s_axi_bvalid;

    wire       wr_fire = aw_have_q & w_have_q;
    wire [7:0] wr_idx  = aw_addr_q[9:2];
    wire       wr_hit_flags = wr_fire & w_strb_q & (aw_addr_q[1:0] == 2'h0) &
                              (wr_idx == `EPC_IDX_IRQ_FLAGS);

    function wr_known;
        input [7:0] idx;
        begin
            wr_known = (idx == `EPC_IDX_MCU_CONTROL) || (idx == `EPC_IDX_IRQ_MASK) ||
                       (idx == `EPC_IDX_IRQ_FLAGS) || (idx == `EPC_IDX_PC_MASK_HI) ||
                       (idx == `EPC_IDX_PC_MASK_LO) || (idx == `EPC_IDX_CORE_CTRL);
        end
    endfunction

    // Address and data accepted in either order; response follows both
    always @(posedge clk)
    begin
        if (rst)
        begin
            aw_have_q    <= 1'b0;
            w_have_q     <= 1'b0;
            aw_addr_q    <= {`EPC_ADDR_W{1'b0}};
            w_byte_q     <= `EPC_RST_REG;
            w_strb_q     <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `EPC_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_q <= 1'b1;
                w_byte_q <= s_axi_wdata[7:0];
                w_strb_q <= s_axi_wstrb[0];
            end
            if (wr_fire)
            begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_known(wr_idx) ? `EPC_RESP_OKAY : `EPC_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Plain read/write registers; lane 0 only carries the byte
    always @(posedge clk)
    begin
        if (rst)
        begin
            mcu_control_q <= `EPC_RST_REG;
            irq_mask_q    <= `EPC_RST_REG;
            pc_mask_hi_q  <= `EPC_RST_REG;
            pc_mask_lo_q  <= `EPC_RST_REG;
            gie_q         <= 1'b0;
        end
        else if (wr_fire && w_strb_q)
        begin
            case (wr_idx)
                `EPC_IDX_MCU_CONTROL: mcu_control_q <= w_byte_q;
                `EPC_IDX_IRQ_MASK:    irq_mask_q    <= w_byte_q & `EPC_IMPL_MASK;
                `EPC_IDX_PC_MASK_HI:  pc_mask_hi_q  <= w_byte_q;
                `EPC_IDX_PC_MASK_LO:  pc_mask_lo_q  <= w_byte_q;
                `EPC_IDX_CORE_CTRL:   gie_q         <= w_byte_q[`EPC_BIT_GIE];
                default:              gie_q         <= gie_q;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Flags: set wins over write-one and vector-entry clear
    // ------------------------------------------------------------------
    wire       ack_ext  = vec_ack & (irq_vector == `EPC_VEC_EXT);
    wire       ack_lo   = vec_ack & (irq_vector == `EPC_VEC_PC_LO);
    wire       ack_hi   = vec_ack & (irq_vector == `EPC_VEC_PC_HI);
    wire [7:0] sw_clr   = wr_hit_flags ? w_byte_q : 8'h00;

    always @*
    begin
        irq_flags_d = irq_flags_q;
        if (sw_clr[`EPC_BIT_EXT] || ack_ext)
            irq_flags_d[`EPC_BIT_EXT] = 1'b0;
        if (ext_edge)
            irq_flags_d[`EPC_BIT_EXT] = 1'b1;
        if (ext_level)
            irq_flags_d[`EPC_BIT_EXT] = 1'b0;
        if (sw_clr[`EPC_BIT_PC_HI] || ack_hi)
            irq_flags_d[`EPC_BIT_PC_HI] = 1'b0;
        if (pc_hi_evt)
            irq_flags_d[`EPC_BIT_PC_HI] = 1'b1;
        if (sw_clr[`EPC_BIT_PC_LO] || ack_lo)
            irq_flags_d[`EPC_BIT_PC_LO] = 1'b0;
        if (pc_lo_evt)
            irq_flags_d[`EPC_BIT_PC_LO] = 1'b1;
        irq_flags_d = irq_flags_d & `EPC_IMPL_MASK;
    end

    always @(posedge clk)
    begin
        if (rst)
            irq_flags_q <= `EPC_RST_REG;
        else
            irq_flags_q <= irq_flags_d;
    end

    // ------------------------------------------------------------------
    // Request arbitration toward the core
    // ------------------------------------------------------------------
    wire ext_pend = irq_mask_q[`EPC_BIT_EXT] &
                    (ext_level ? ext_level_req : irq_flags_q[`EPC_BIT_EXT]);
    wire lo_pend  = irq_mask_q[`EPC_BIT_PC_LO] & irq_flags_q[`EPC_BIT_PC_LO];
    wire hi_pend  = irq_mask_q[`EPC_BIT_PC_HI] & irq_flags_q[`EPC_BIT_PC_HI];

    // Lowest vector number wins
    reg [15:0] vec_d;
    reg        any_d;
    always @*
    begin
        any_d = 1'b1;
        if (ext_pend)             vec_d = `EPC_VEC_EXT;
        else if (lo_pend)         vec_d = `EPC_VEC_PC_LO;
        else if (hi_pend)         vec_d = `EPC_VEC_PC_HI;
        else if (wdt_irq_req)     vec_d = `EPC_VEC_WDT;
        else if (tmr_irq_req[0])  vec_d = `EPC_VEC_TMR1_CMP_A;
        else if (tmr_irq_req[1])  vec_d = `EPC_VEC_TMR1_CMP_B;
        else if (tmr_irq_req[2])  vec_d = `EPC_VEC_TMR1_WRAP;
        else if (tmr_irq_req[3])  vec_d = `EPC_VEC_TMR0_CMP_A;
        else if (tmr_irq_req[4])  vec_d = `EPC_VEC_TMR0_CMP_B;
        else if (tmr_irq_req[5])  vec_d = `EPC_VEC_TMR0_WRAP;
        else
        begin
            vec_d = `EPC_VEC_RESET;
            any_d = 1'b0;
        end
    end

    reg irq_pend_q;
    always @(posedge clk)
    begin
        if (rst)
        begin
            irq_vector   <= `EPC_VEC_RESET;
            irq_pend_q   <= 1'b0;
            reset_vector <= `EPC_VEC_RESET;
        end
        else
        begin
            // Drop the request the cycle it is taken so the flag clear lands first
            irq_pend_q <= any_d & ~vec_ack;
            irq_vector <= vec_d;
        end
    end

    // Global enable gates delivery; a level that vanished before start-up
    // ends still wakes, but no request is presented
    assign irq_req  = irq_pend_q & gie_q & start_up_done;
    // A low level on a masked pin must not wake the part
    assign wake_req = irq_pend_q | (ext_level_req & irq_mask_q[`EPC_BIT_EXT]);

    // ------------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------------
    assign s_axi_arready = ~s_axi_rvalid;
    wire [7:0] rd_idx = s_axi_araddr[9:2];

    always @(posedge clk)
    begin
        if (rst)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `EPC_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `EPC_RESP_OKAY;
            case (rd_idx)
                `EPC_IDX_MCU_CONTROL: s_axi_rdata <= {24'h000000, mcu_control_q};
                `EPC_IDX_IRQ_MASK:    s_axi_rdata <= {24'h000000, irq_mask_q};
                `EPC_IDX_IRQ_FLAGS:   s_axi_rdata <= {24'h000000, irq_flags_q};
                `EPC_IDX_PC_MASK_HI:  s_axi_rdata <= {24'h000000, pc_mask_hi_q};
                `EPC_IDX_PC_MASK_LO:  s_axi_rdata <= {24'h000000, pc_mask_lo_q};
                `EPC_IDX_CORE_CTRL:   s_axi_rdata <= {24'h000000, gie_q, 7'h00};
                default:
                begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `EPC_RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule // epc_irq_unit

// ---- hw/epc_defs.vh ----
// Purpose: Offsets, field positions, reset values and vector codes of the
//          external pin and pin-change interrupt unit.
// Assumes: Byte addresses on an AXI4-Lite register bus.
// Notes:   Definitions only.
`ifndef EPC_DEFS_VH
`define EPC_DEFS_VH

// ----------------------------------------------------------------------
// Register indices and byte address width
// ----------------------------------------------------------------------
`define EPC_IDX_MCU_CONTROL     8'h35
`define EPC_IDX_IRQ_MASK        8'h3B
`define EPC_IDX_IRQ_FLAGS       8'h3A
`define EPC_IDX_PC_MASK_HI      8'h20
`define EPC_IDX_PC_MASK_LO      8'h12
`define EPC_IDX_CORE_CTRL       8'h3F
`define EPC_ADDR_W              10

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define EPC_BIT_EXT             6
`define EPC_BIT_PC_HI           5
`define EPC_BIT_PC_LO           4
`define EPC_BIT_GIE             7
`define EPC_IMPL_MASK           8'h70

// ----------------------------------------------------------------------
// Reset values and sense codes
// ----------------------------------------------------------------------
`define EPC_RST_REG             8'h00
`define EPC_SENSE_LOW           2'h0
`define EPC_SENSE_ANY           2'h1
`define EPC_SENSE_FALL          2'h2
`define EPC_SENSE_RISE          2'h3

// ----------------------------------------------------------------------
// Vector addresses
// ----------------------------------------------------------------------
`define EPC_VEC_RESET           16'h0000
`define EPC_VEC_EXT             16'h0001
`define EPC_VEC_PC_LO           16'h0002
`define EPC_VEC_PC_HI           16'h0003
`define EPC_VEC_WDT             16'h0004
`define EPC_VEC_TMR1_CMP_A      16'h0005
`define EPC_VEC_TMR1_CMP_B      16'h0006
`define EPC_VEC_TMR1_WRAP       16'h0007
`define EPC_VEC_TMR0_CMP_A      16'h0008
`define EPC_VEC_TMR0_CMP_B      16'h0009
`define EPC_VEC_TMR0_WRAP       16'h000A

// AXI responses
`define EPC_RESP_OKAY           2'h0
`define EPC_RESP_SLVERR         2'h2

`endif

// ---- testbench/epc_irq_chk.sv ----
// Purpose: Port-level assertions for the pin and pin-change interrupt unit.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   Bound from the bench top; sees only ports of the unit.
`timescale 1ns/1ps
module epc_irq_chk (
    input wire        clk,
    input wire        rst,
    input wire        s_axi_awready,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire [5:0]  tmr_irq_req,
    input wire        start_up_done,
    input wire        irq_req,
    input wire [15:0] irq_vector,
    input wire [15:0] reset_vector
);
// ------------------------------------------------------------
// Properties
// ------------------------------------------------------------
default clocking cb @(posedge clk); endclocking
default disable iff (rst);
// Bus handshake and two-cycle request shapes
sequence s_ar_take;
    s_axi_arvalid && s_axi_arready;
endsequence
sequence s_r_stall;
    s_axi_rvalid && !s_axi_rready;
endsequence
sequence s_t1a_held;
    tmr_irq_req[0] ##1 tmr_irq_req[0];
endsequence
AST_RST_VEC: assert property (reset_vector == 16'h0000)
    else $error("reset vector not zero");
AST_GATE: assert property (irq_req |-> start_up_done)
    else $error("request before start-up done");
AST_VEC_RANGE: assert property (irq_req && $past(irq_req) |-> irq_vector >= 16'h0001 && irq_vector <= 16'h000A)
    else $error("request with vector out of range");
AST_TMR_PRIO: assert property (s_t1a_held |-> irq_vector != 16'h0000 && irq_vector <= 16'h0005)
    else $error("lower pending vector not presented");
AST_AR_READY: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("arready not inverse of rvalid");
AST_R_LAT: assert property (s_ar_take |=> s_axi_rvalid)
    else $error("read answer late");
AST_R_HOLD: assert property (s_r_stall |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
AST_B_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken with response pending");
endmodule // epc_irq_chk

// ---- testbench/epc_core_model.sv ----
// Purpose: Core-side partner: start-up gate and vector entry acknowledge.
// Assumes: Acknowledge pulses one cycle; the vector is taken with it.
// Notes:   ack_dly sets how slowly the core enters a routine.
`timescale 1ns/1ps
module epc_core_model (
    input  wire        clk,
    input  wire        rst,
    input  wire        irq_req,
    input  wire [15:0] irq_vector,
    input  wire        ack_en,
    input  wire [3:0]  ack_dly,
    input  wire        hold_start,
    output wire        start_up_done,
    output reg         vec_ack,
    output reg  [15:0] last_vec,
    output reg  [7:0]  n_taken
);
reg [3:0] wait_q;
reg [1:0] cool_q;
// Vector entry is held off until start-up ends
assign start_up_done = ~hold_start;
// Cool-down lets the cleared request fall before the next entry
always @(posedge clk)
begin
    vec_ack <= 1'b0;
    if (rst)
    begin
        wait_q   <= 4'h0;
        cool_q   <= 2'h0;
        last_vec <= 16'h0000;
        n_taken  <= 8'h00;
    end
    else if (vec_ack)
    begin
        last_vec <= irq_vector;
        n_taken  <= n_taken + 8'h01;
    end
    else if (cool_q != 2'h0)
        cool_q <= cool_q - 2'h1;
    else if (ack_en && irq_req && wait_q == ack_dly)
    begin
        vec_ack <= 1'b1;
        wait_q  <= 4'h0;
        cool_q  <= 2'h3;
    end
    else if (ack_en && irq_req)
        wait_q <= wait_q + 4'h1;
    else
        wait_q <= 4'h0;
end
endmodule // epc_core_model

// ---- testbench/epc_irq_unit_tb.sv ----
// Purpose: Self-checking bench for the pin and pin-change interrupt unit.
// Assumes: Register byte address is index times four.
// Notes:   Pins change on clock edges; flags are read after six cycles.
`timescale 1ns/1ps
`include "epc_defs.vh"
module epc_irq_unit_tb;
localparam [7:0] ix_mcu = `EPC_IDX_MCU_CONTROL;
localparam [7:0] ix_msk = `EPC_IDX_IRQ_MASK;
localparam [7:0] ix_flg = `EPC_IDX_IRQ_FLAGS;
reg         clk = 1'b0, rst = 1'b1, ext_pin = 1'b1, wdt = 1'b0;
reg         awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, rready = 1'b0;
reg         hold_start = 1'b0, ack_en = 1'b0;
reg  [9:0]  awaddr = 10'h000, araddr = 10'h000;
reg  [31:0] wdata = 32'h0, rd_w;
reg  [15:0] pins = 16'h0000;
reg  [5:0]  tmr = 6'h00;
reg  [3:0]  ack_dly = 4'h0;
reg  [1:0]  rd_r, wr_b;
wire        awready, wready, bvalid, arready, rvalid, irq_req, wake_req, vec_ack, sud;
wire [1:0]  bresp, rresp;
wire [31:0] rdata;
wire [15:0] irq_vector, reset_vector, last_vec;
wire [7:0]  n_taken;
integer     n_errors = 0, n_tests = 0, i;
always #4 clk = ~clk;
epc_irq_unit dut_u (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ext_irq_pin(ext_pin), .pin_change_input(pins), .tmr_irq_req(tmr), .wdt_irq_req(wdt),
    .start_up_done(sud), .vec_ack(vec_ack), .irq_req(irq_req), .irq_vector(irq_vector),
    .wake_req(wake_req), .reset_vector(reset_vector));
epc_core_model core_u (.clk(clk), .rst(rst), .irq_req(irq_req), .irq_vector(irq_vector),
    .ack_en(ack_en), .ack_dly(ack_dly), .hold_start(hold_start), .start_up_done(sud),
    .vec_ack(vec_ack), .last_vec(last_vec), .n_taken(n_taken));
// ------------------------------------------------------------
// Checking and bus tasks
// ------------------------------------------------------------
task chk(input [31:0] got, input [31:0] exp);
begin
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
        n_errors = n_errors + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
end
endtask
task print_verdict;
begin
    $display("tests=%0d errors=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
        $display("TB: PASS");
    else
        $display("TB: FAIL");
    $finish;
end
endtask
task tmo;
begin
    n_errors = n_errors + 1;
    print_verdict;
end
endtask
// Handshakes are judged at the falling edge, where nothing moves
task wr(input [7:0] idx, input [7:0] d);
    integer k;
    reg     a, w, b;
begin
    b = 1'b0;
    awaddr  <= {idx, 2'b00};
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    for (k = 0; k < 50 && !b; k = k + 1)
    begin
        @(negedge clk);
        a = awvalid && awready;
        w = wvalid && wready;
        b = bvalid;
        wr_b = bresp;
        @(posedge clk);
        if (a) awvalid <= 1'b0;
        if (w) wvalid <= 1'b0;
    end
    if (!b) tmo;
end
endtask
// rready rises late on purpose so the held answer is exercised
task rd(input [7:0] idx);
    integer k;
    reg     a, v, r;
begin
    r = 1'b0;
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    for (k = 0; k < 50 && !r; k = k + 1)
    begin
        @(negedge clk);
        a = arvalid && arready;
        v = rvalid;
        r = rvalid && rready;
        rd_w = rdata;
        rd_r = rresp;
        @(posedge clk);
        if (a) arvalid <= 1'b0;
        if (r) rready <= 1'b0;
        else if (v) rready <= 1'b1;
    end
    if (!r) tmo;
end
endtask
task rd_chk(input [7:0] idx, input [31:0] exp);
begin
    rd(idx);
    chk(rd_w, exp);
end
endtask
// ------------------------------------------------------------
// Scenarios
// ------------------------------------------------------------
task t_regs;
begin
    chk(reset_vector, 32'h0);
    rd_chk(ix_mcu, 32'h0);
    rd_chk(ix_msk, 32'h0);
    rd_chk(ix_flg, 32'h0);
    rd_chk(`EPC_IDX_PC_MASK_HI, 32'h0);
    rd_chk(`EPC_IDX_PC_MASK_LO, 32'h0);
    wr(ix_msk, 8'hFF);
    chk(wr_b, `EPC_RESP_OKAY);
    rd_chk(ix_msk, 32'h70);
    wr(ix_flg, 8'h8F);
    rd_chk(ix_flg, 32'h0);
    rd(8'h01);
    chk(rd_r, `EPC_RESP_SLVERR);
    wr(8'h01, 8'h00);
    chk(wr_b, `EPC_RESP_SLVERR);
end
endtask
// Masked pin first, then one enabled pin of each group
task t_pc;
begin
    wr(`EPC_IDX_PC_MASK_LO, 8'h01);
    wr(`EPC_IDX_PC_MASK_HI, 8'h80);
    pins <= 16'h0002;
    repeat (6) @(posedge clk);
    rd_chk(ix_flg, 32'h0);
    pins <= 16'h8003;
    repeat (6) @(posedge clk);
    rd_chk(ix_flg, 32'h30);
    wr(ix_flg, 8'h10);
    rd_chk(ix_flg, 32'h20);
    wr(ix_flg, 8'h20);
    rd_chk(ix_flg, 32'h0);
end
endtask
// Every sense code; low level is held far past one instruction
task t_sense;
    integer m;
begin
    for (m = 1; m < 4; m = m + 1)
    begin
        wr(ix_mcu, m[7:0]);
        ext_pin <= 1'b0;
        repeat (6) @(posedge clk);
        rd_chk(ix_flg, (m != 3) ? 32'h40 : 32'h0);
        wr(ix_flg, 8'h40);
        ext_pin <= 1'b1;
        repeat (6) @(posedge clk);
        rd_chk(ix_flg, (m != 2) ? 32'h40 : 32'h0);
        wr(ix_flg, 8'h40);
    end
    wr(ix_mcu, 8'h00);
    ext_pin <= 1'b0;
    repeat (6) @(posedge clk);
    rd_chk(ix_flg, 32'h0);
    chk(irq_req, 1'b0);
    chk(wake_req, 1'b1);
    wr(`EPC_IDX_CORE_CTRL, 8'h80);
    chk(irq_req, 1'b1);
    chk(irq_vector, 16'h0001);
    ext_pin <= 1'b1;
    repeat (6) @(posedge clk);
    chk(irq_req, 1'b0);
end
endtask
// Two sources pend together; the slow core takes them in order
task t_order;
    integer k;
begin
    wr(ix_mcu, 8'h02);
    ext_pin <= 1'b0;
    pins    <= 16'h8002;
    repeat (6) @(posedge clk);
    chk(irq_vector, 16'h0001);
    ack_dly <= 4'h3;
    ack_en  <= 1'b1;
    for (k = 0; k < 60 && n_taken < 8'h01; k = k + 1)
        @(posedge clk);
    if (n_taken < 8'h01) tmo;
    chk(last_vec, 16'h0001);
    for (k = 0; k < 60 && n_taken < 8'h02; k = k + 1)
        @(posedge clk);
    if (n_taken < 8'h02) tmo;
    chk(last_vec, 16'h0002);
    ack_en  <= 1'b0;
    ext_pin <= 1'b1;
    rd_chk(ix_flg, 32'h0);
end
endtask
// Start-up gate, then the timer and watchdog table
task t_start;
begin
    hold_start <= 1'b1;
    tmr        <= 6'h01;
    repeat (4) @(posedge clk);
    chk(irq_req, 1'b0);
    chk(wake_req, 1'b1);
    hold_start <= 1'b0;
    repeat (2) @(posedge clk);
    chk(irq_req, 1'b1);
    for (i = 0; i < 6; i = i + 1)
    begin
        tmr <= 6'h01 << i;
        repeat (3) @(posedge clk);
        chk(irq_vector, 16'h0005 + i);
    end
    tmr <= 6'h01;
    wdt <= 1'b1;
    repeat (3) @(posedge clk);
    chk(irq_vector, 16'h0004);
    tmr <= 6'h00;
    wdt <= 1'b0;
end
endtask
initial
begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    t_regs;
    t_pc;
    t_sense;
    t_order;
    t_start;
    print_verdict;
end
// Run-length guard
initial
begin
    #400000;
    tmo;
end
endmodule // epc_irq_unit_tb
bind epc_irq_unit epc_irq_chk chk_u (.clk(clk), .rst(rst), .s_axi_awready(s_axi_awready),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .tmr_irq_req(tmr_irq_req), .start_up_done(start_up_done),
    .irq_req(irq_req), .irq_vector(irq_vector), .reset_vector(reset_vector));
